//--- verilog/piad_pkg.sv
// Notes on behaviour
// - Global enable gates every main memory select
// - Low 512 KB follows global enable only
// - 512-640 KB and BIOS area per-direction enables
// - C and D regions: eight 16 KB segments
// - E region: four 16 KB segments
// - Select from 1 MB to programmable top
// - Programmable hole suppresses the select
// - Select driven edge after frame start sampled
// - Select lasts exactly one clock, nothing else
// - Unclaimed cycles forwarded, DEVSEL driven by us
// - Fast, typical, slow DEVSEL sample points
// - Own select counts as early claim
// - No forward above 16M memory except two BIOS alias ranges, above 64K I/O
// - ISA cycles reach PCI only when decoded
// - Fixed ISA regions below F0000 have own enable bits
// - Expansion ROM in eight 16K enable sections
// - ISA region from 1 MB to top field
// - ISA hole, up to 8 MB, not forwarded
// - ISA addresses above 16 MB always forwarded
// - Sixteen select ranges, two without direction
package piad_pkg;
  localparam logic [11:0] OFF_MEM_CTL     = 12'h000;
  localparam logic [11:0] OFF_ATTR_C      = 12'h004;
  localparam logic [11:0] OFF_ATTR_D      = 12'h008;
  localparam logic [11:0] OFF_ATTR_E      = 12'h00C;
  localparam logic [11:0] OFF_MEM_TOP     = 12'h010;
  localparam logic [11:0] OFF_MEM_HBOT    = 12'h014;
  localparam logic [11:0] OFF_MEM_HTOP    = 12'h018;
  localparam logic [11:0] OFF_ISA_CTL     = 12'h01C;
  localparam logic [11:0] OFF_ISA_ROM     = 12'h020;
  localparam logic [11:0] OFF_ISA_HBOT    = 12'h024;
  localparam logic [11:0] OFF_ISA_HTOP    = 12'h028;
  localparam logic [11:0] OFF_SAMPLE_CFG  = 12'h02C;
  localparam logic [11:0] OFF_STATUS      = 12'h030;

  localparam logic [7:0]  RST_REG8        = 8'h00;
  localparam logic [1:0]  RST_SAMPLE      = 2'h2;

  localparam int          CTL_LOWMID_RD   = 0;
  localparam int          CTL_LOWMID_WR   = 1;
  localparam int          CTL_BIOS_RD     = 2;
  localparam int          CTL_BIOS_WR     = 3;
  localparam int          CTL_GLOBAL      = 4;
  localparam int          ICTL_LOW        = 0;
  localparam int          ICTL_MID        = 1;
  localparam int          ICTL_VIDEO      = 2;
  localparam int          ICTL_LBIOS      = 3;

  localparam logic [1:0]  SAMPLE_FAST     = 2'h0;
  localparam logic [1:0]  SAMPLE_TYPICAL  = 2'h1;
  localparam logic [1:0]  SAMPLE_SLOW     = 2'h2;
  localparam logic [1:0]  POINT_F         = 2'h1;
  localparam logic [1:0]  POINT_T         = 2'h2;
  localparam logic [1:0]  POINT_S         = 2'h3;

  localparam logic [3:0]  CMD_IO_RD       = 4'h2;
  localparam logic [3:0]  CMD_IO_WR       = 4'h3;
  localparam logic [3:0]  CMD_MEM_RD      = 4'h6;
  localparam logic [3:0]  CMD_MEM_WR      = 4'h7;
  localparam logic [3:0]  CMD_MEM_RDM     = 4'hC;
  localparam logic [3:0]  CMD_MEM_RDL     = 4'hE;
  localparam logic [3:0]  CMD_MEM_WRI     = 4'hF;

  localparam logic [7:0]  HOLE_MIN_BLK    = 8'h10;
  localparam logic [14:0] BIOS_ALIAS_TOP  = 15'h7FFF;
  localparam logic [14:0] BIOS_ALIAS_LOW  = 15'h7FF7;

  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_DECODE = 5'b00010,
    ST_CLAIM  = 5'b00100,
    ST_FWD    = 5'b01000,
    ST_WAIT   = 5'b10000
  } piad_state_t;
endpackage : piad_pkg

//--- verilog/piad_hole_check.sv
`timescale 1ns/1ps
`default_nettype none
module piad_hole_check #(
  parameter int BW         = 8,
  parameter int MAX_BLOCKS = 256
) (
  input  wire logic [BW-1:0] blk,
  input  wire logic          in_space,
  input  wire logic [BW-1:0] bottom,
  input  wire logic [BW-1:0] top,
  output logic               hit
);
  import piad_pkg::*;
  logic [BW:0] span;

  always_comb begin
    span = {1'b0, blk} - {1'b0, bottom};
    hit  = in_space && (bottom >= BW'(HOLE_MIN_BLK)) && (top >= bottom)
           && (blk >= bottom) && (blk <= top) && (span < (BW+1)'(MAX_BLOCKS));
  end
endmodule : piad_hole_check
`default_nettype wire

//--- verilog/piad_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module piad_decoder #(
  parameter int ISA_HOLE_BLOCKS = 128
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        frame_n,
  input  wire logic        irdy_n,
  input  wire logic [31:0] pci_addr,
  input  wire logic [3:0]  pci_cmd,
  input  wire logic        devsel_n_rx,
  output logic             devsel_n_drive,
  output logic             devsel_oe,
  output logic             main_memory_select_n,
  output logic             isa_forward,
  input  wire logic        isa_req,
  input  wire logic [31:0] isa_addr,
  output logic             forward_to_pci,
  output logic             contain_to_isa
);
  import piad_pkg::*;

  typedef struct packed {
    piad_state_t st;
    logic [1:0]  cnt;
    logic [31:0] addr_q;
    logic [3:0]  cmd_q;
    logic        sel;
    logic        sel_seen;
    logic        devsel_drv;
    logic        fwd;
    logic [7:0]  ctl;
    logic [7:0]  attr_c;
    logic [7:0]  attr_d;
    logic [7:0]  attr_e;
    logic [7:0]  mtop;
    logic [7:0]  mhbot;
    logic [7:0]  mhtop;
    logic [7:0]  ictl;
    logic [7:0]  irom;
    logic [7:0]  ihbot;
    logic [7:0]  ihtop;
    logic [1:0]  scfg;
    logic [31:0] prdata;
    logic        to_pci;
    logic        to_isa;
  } piad_regs_t;

  piad_regs_t s;
  piad_regs_t next_s;

  logic        is_mem;
  logic        is_io;
  logic        is_wr;
  logic        below_1m;
  logic        mem_hole_hit;
  logic        isa_hole_hit;
  logic        sel_hit;
  logic        forwardable;
  logic        claimed;
  logic [1:0]  last_point;
  logic        isa_hit;
  logic        wr_en;
  logic        mapped;
  logic [31:0] rd_val;
  logic [7:0]  seg_attr;

  // Hole in the select region, 1 MB to 16 MB
  piad_hole_check #(
    .BW         (8),
    .MAX_BLOCKS (256)
  ) u_mem_hole (
    .blk      (s.addr_q[23:16]),
    .in_space (s.addr_q[31:24] == 8'h00),
    .bottom   (s.mhbot),
    .top      (s.mhtop),
    .hit      (mem_hole_hit)
  );

  // Hole in the ISA forward region, size capped
  piad_hole_check #(
    .BW         (8),
    .MAX_BLOCKS (ISA_HOLE_BLOCKS)
  ) u_isa_hole (
    .blk      (isa_addr[23:16]),
    .in_space (isa_addr[31:24] == 8'h00),
    .bottom   (s.ihbot),
    .top      (s.ihtop),
    .hit      (isa_hole_hit)
  );

  // Command class and select decode on captured address
  always_comb begin
    is_mem   = (s.cmd_q == CMD_MEM_RD) || (s.cmd_q == CMD_MEM_WR) ||
               (s.cmd_q == CMD_MEM_RDM) || (s.cmd_q == CMD_MEM_RDL) ||
               (s.cmd_q == CMD_MEM_WRI);
    is_io    = (s.cmd_q == CMD_IO_RD) || (s.cmd_q == CMD_IO_WR);
    is_wr    = (s.cmd_q == CMD_MEM_WR) || (s.cmd_q == CMD_MEM_WRI);
    below_1m = (s.addr_q[31:20] == 12'h000);
    seg_attr = s.addr_q[16] ? s.attr_d : s.attr_c;
    sel_hit  = 1'b0;
    if (s.addr_q[31:19] == 13'h0000) begin
      sel_hit = 1'b1;
    end else if (below_1m && s.addr_q[19:17] == 3'b100) begin
      sel_hit = is_wr ? s.ctl[CTL_LOWMID_WR] : s.ctl[CTL_LOWMID_RD];
    end else if (below_1m && s.addr_q[19:16] == 4'hF) begin
      sel_hit = is_wr ? s.ctl[CTL_BIOS_WR] : s.ctl[CTL_BIOS_RD];
    end else if (below_1m && s.addr_q[19:17] == 3'b110) begin
      sel_hit = seg_attr[{s.addr_q[15:14], is_wr}];
    end else if (below_1m && s.addr_q[19:16] == 4'hE) begin
      sel_hit = s.attr_e[{s.addr_q[15:14], is_wr}];
    end else if (!below_1m) begin
      sel_hit = (s.addr_q[31:21] <= {3'b000, s.mtop});
    end
    sel_hit = sel_hit && s.ctl[CTL_GLOBAL] && is_mem && !mem_hole_hit;
    forwardable = (is_mem && s.addr_q[31:24] == 8'h00) ||
                  (is_io && s.addr_q[31:16] == 16'h0000) ||
                  (is_mem && (s.addr_q[31:17] == BIOS_ALIAS_TOP ||
                              s.addr_q[31:17] == BIOS_ALIAS_LOW));
    claimed = s.sel_seen || !devsel_n_rx;
    case (s.scfg)
      SAMPLE_FAST:    last_point = POINT_F;
      SAMPLE_TYPICAL: last_point = POINT_T;
      default:        last_point = POINT_S;
    endcase
  end

  // ISA master and DMA positive decode
  always_comb begin
    isa_hit = 1'b0;
    if (isa_addr[31:24] != 8'h00) begin
      isa_hit = 1'b1;
    end else if (isa_addr[23:20] != 4'h0) begin
      isa_hit = (isa_addr[23:20] <= s.ictl[7:4]) && !isa_hole_hit;
    end else if (isa_addr[19] == 1'b0) begin
      isa_hit = s.ictl[ICTL_LOW];
    end else if (isa_addr[19:17] == 3'b100) begin
      isa_hit = s.ictl[ICTL_MID];
    end else if (isa_addr[19:17] == 3'b101) begin
      isa_hit = s.ictl[ICTL_VIDEO];
    end else if (isa_addr[19:17] == 3'b110) begin
      isa_hit = s.irom[isa_addr[16:14]];
    end else if (isa_addr[19:16] == 4'hE) begin
      isa_hit = s.ictl[ICTL_LBIOS];
    end
  end

  // Register read mux and address check
  always_comb begin
    mapped = (paddr[1:0] == 2'b00) && (paddr <= OFF_STATUS);
    rd_val = 32'h0000_0000;
    case (paddr)
      OFF_MEM_CTL:    rd_val = {24'h000000, s.ctl};
      OFF_ATTR_C:     rd_val = {24'h000000, s.attr_c};
      OFF_ATTR_D:     rd_val = {24'h000000, s.attr_d};
      OFF_ATTR_E:     rd_val = {24'h000000, s.attr_e};
      OFF_MEM_TOP:    rd_val = {24'h000000, s.mtop};
      OFF_MEM_HBOT:   rd_val = {24'h000000, s.mhbot};
      OFF_MEM_HTOP:   rd_val = {24'h000000, s.mhtop};
      OFF_ISA_CTL:    rd_val = {24'h000000, s.ictl};
      OFF_ISA_ROM:    rd_val = {24'h000000, s.irom};
      OFF_ISA_HBOT:   rd_val = {24'h000000, s.ihbot};
      OFF_ISA_HTOP:   rd_val = {24'h000000, s.ihtop};
      OFF_SAMPLE_CFG: rd_val = {30'h0, s.scfg};
      OFF_STATUS:     rd_val = {24'h000000, s.to_isa, s.to_pci, s.devsel_drv, s.st};
      default:        rd_val = 32'h0000_0000;
    endcase
    wr_en = psel && penable && pwrite && mapped;
  end

  always_comb begin
    next_s        = s;
    next_s.sel    = 1'b0;
    next_s.fwd    = 1'b0;
    next_s.to_pci = 1'b0;
    next_s.to_isa = 1'b0;
    if (psel && !penable && !pwrite) begin
      next_s.prdata = rd_val;
    end
    if (wr_en) begin
      case (paddr)
        OFF_MEM_CTL:    next_s.ctl    = pwdata[7:0];
        OFF_ATTR_C:     next_s.attr_c = pwdata[7:0];
        OFF_ATTR_D:     next_s.attr_d = pwdata[7:0];
        OFF_ATTR_E:     next_s.attr_e = pwdata[7:0];
        OFF_MEM_TOP:    next_s.mtop   = pwdata[7:0];
        OFF_MEM_HBOT:   next_s.mhbot  = pwdata[7:0];
        OFF_MEM_HTOP:   next_s.mhtop  = pwdata[7:0];
        OFF_ISA_CTL:    next_s.ictl   = pwdata[7:0];
        OFF_ISA_ROM:    next_s.irom   = pwdata[7:0];
        OFF_ISA_HBOT:   next_s.ihbot  = pwdata[7:0];
        OFF_ISA_HTOP:   next_s.ihtop  = pwdata[7:0];
        OFF_SAMPLE_CFG: next_s.scfg   = pwdata[1:0];
        default:        next_s.ctl    = s.ctl;
      endcase
    end
    if (isa_req) begin
      next_s.to_pci = isa_hit;
      next_s.to_isa = !isa_hit;
    end
    case (s.st)
      ST_IDLE: begin
        if (!frame_n) begin
          next_s.addr_q = pci_addr;
          next_s.cmd_q  = pci_cmd;
          next_s.st     = ST_DECODE;
        end
      end
      ST_DECODE: begin
        next_s.sel      = sel_hit;
        next_s.sel_seen = sel_hit;
        next_s.cnt      = POINT_F;
        next_s.st       = ST_CLAIM;
      end
      ST_CLAIM: begin
        if (claimed) begin
          next_s.st = ST_WAIT;
        end else if (s.cnt == last_point) begin
          if (forwardable) begin
            next_s.devsel_drv = 1'b1;
            next_s.fwd        = 1'b1;
            next_s.st         = ST_FWD;
          end else begin
            next_s.st = ST_WAIT;
          end
        end else begin
          next_s.cnt = s.cnt + 2'h1;
        end
      end
      ST_FWD, ST_WAIT: begin
        if (frame_n && irdy_n) begin
          next_s.devsel_drv = 1'b0;
          next_s.sel_seen   = 1'b0;
          next_s.st         = ST_IDLE;
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s        <= '0;
      s.st     <= ST_IDLE;
      s.scfg   <= RST_SAMPLE;
      s.ctl    <= RST_REG8;
    end else begin
      s <= next_s;
    end
  end

  assign prdata               = s.prdata;
  assign pready               = 1'b1;
  assign pslverr              = psel && penable && !mapped;
  assign devsel_n_drive       = !s.devsel_drv;
  assign devsel_oe            = s.devsel_drv;
  assign main_memory_select_n = !s.sel;
  assign isa_forward          = s.fwd;
  assign forward_to_pci       = s.to_pci;
  assign contain_to_isa       = s.to_isa;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic frame_start;
  assign frame_start = (s.st == ST_IDLE) && !frame_n;

  sequence sel_pulse_s;
    !main_memory_select_n ##1 main_memory_select_n;
  endsequence

  sequence fwd_drive_s;
    isa_forward && devsel_oe && !devsel_n_drive ##1 !isa_forward && devsel_oe;
  endsequence

  global_gate_a: assert property (
    !main_memory_select_n |-> $past(s.ctl[CTL_GLOBAL]))
    else $error("select without global enable");

  low_range_a: assert property (
    (s.st == ST_DECODE) && s.ctl[CTL_GLOBAL] && is_mem && (s.addr_q[31:19] == 13'h0000)
    |=> !main_memory_select_n)
    else $error("low range not selected");

  sel_timing_a: assert property (
    !main_memory_select_n |-> $past(frame_start, 2))
    else $error("select not two edges after frame start");

  sel_single_a: assert property (
    $fell(main_memory_select_n) |-> sel_pulse_s)
    else $error("select longer than one clock");

  hole_block_a: assert property (
    !main_memory_select_n |-> !$past(mem_hole_hit))
    else $error("select inside hole");

  fwd_devsel_a: assert property (
    $rose(isa_forward) |-> fwd_drive_s)
    else $error("forward without own devsel");

  early_claim_a: assert property (
    $fell(main_memory_select_n) |-> (!isa_forward)[*5])
    else $error("selected cycle forwarded");

  fast_point_a: assert property (
    (s.st == ST_CLAIM) && (s.scfg == SAMPLE_FAST) && devsel_n_rx && !s.sel_seen
    && forwardable |=> isa_forward)
    else $error("fast point did not forward");

  no_alias_a: assert property (
    $rose(isa_forward) |-> $past(forwardable))
    else $error("forward above decoded limits");

  isa_high_a: assert property (
    isa_req && (isa_addr[31:24] != 8'h00) |=> forward_to_pci && !contain_to_isa)
    else $error("high isa address not forwarded");

  isa_rom_a: assert property (
    isa_req && (isa_addr[31:17] == 15'h0006) |=> forward_to_pci == $past(s.irom[isa_addr[16:14]]))
    else $error("rom section enable ignored");
endmodule : piad_decoder
`default_nettype wire

//--- dv/piad_pci_agent.sv
`timescale 1ns/1ps
`default_nettype none
module piad_pci_agent (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       frame_n,
  input  wire logic       irdy_n,
  input  wire logic       main_memory_select_n,
  input  wire logic       devsel_n_drive,
  input  wire logic       devsel_oe,
  input  wire logic [2:0] claim_at,
  output logic            devsel_n_rx
);
  logic [3:0] cnt;
  logic       sel_claim;
  // Edge count of the running frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= 4'h0;
      sel_claim <= 1'b0;
    end else if (frame_n && irdy_n) begin
      cnt       <= 4'h0;
      sel_claim <= 1'b0;
    end else begin
      cnt       <= (cnt == 4'hF) ? cnt : cnt + 4'h1;
      sel_claim <= sel_claim | ~main_memory_select_n;
    end
  end
  // Wired level, pulled up when nobody drives
  assign devsel_n_rx = ~(sel_claim | (devsel_oe & ~devsel_n_drive)
                       | (claim_at != 3'h0 && cnt >= {1'b0, claim_at}));
endmodule : piad_pci_agent
`default_nettype wire

//--- dv/pci_isa_address_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pci_isa_address_decoder_tb_top;
  import piad_pkg::*;
  typedef struct packed {
    logic [7:0]  mctl;
    logic [1:0]  cfg;
    logic [2:0]  claim;
    logic [3:0]  cmd;
    logic [31:0] addr;
    logic        sel;
    logic        fwd;
  } piad_row_t;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pci_addr, isa_addr;
  logic [3:0]  pci_cmd;
  logic [2:0]  claim_at;
  logic        frame_n, irdy_n, devsel_n_rx, devsel_n_drive, devsel_oe;
  logic        main_memory_select_n, isa_forward, isa_req, forward_to_pci, contain_to_isa;
  int          error_cnt, n_compared;
  piad_row_t   rows [29] = '{
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h1000, 1'b1, 1'b0},
    '{8'h0F, 2'h2, 3'h0, CMD_MEM_RD, 32'h1000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'h7FFFC, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h80000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'h9FFF0, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'hF0000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WRI, 32'hFFFF0, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RDL, 32'hC0000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'hC0000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'hDC000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RDM, 32'hDC000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'hE0000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'hEC000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'hA0000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h100000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h3FFFFC, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h400000, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h18FFFC, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'h190000, 1'b1, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_IO_WR, 32'h3F8, 1'b0, 1'b1},
    '{8'h15, 2'h2, 3'h0, CMD_IO_RD, 32'h10000, 1'b0, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_WR, 32'h1000000, 1'b0, 1'b0},
    '{8'h15, 2'h2, 3'h0, CMD_MEM_RD, 32'hFFFF0000, 1'b0, 1'b1},
    '{8'h15, 2'h0, 3'h3, CMD_IO_RD, 32'h3F8, 1'b0, 1'b1},
    '{8'h15, 2'h0, 3'h2, CMD_IO_RD, 32'h3F8, 1'b0, 1'b0},
    '{8'h15, 2'h1, 3'h3, CMD_IO_RD, 32'h3F8, 1'b0, 1'b0},
    '{8'h15, 2'h1, 3'h4, CMD_IO_RD, 32'h3F8, 1'b0, 1'b1},
    '{8'h15, 2'h1, 3'h0, CMD_MEM_RD, 32'h1000, 1'b1, 1'b0},
    '{8'h15, 2'h3, 3'h4, CMD_IO_RD, 32'h3F8, 1'b0, 1'b0}
  };
  logic [32:0] isa_rows [16] = '{{32'h0, 1'b1}, {32'h80000, 1'b0}, {32'hA0000, 1'b1},
    {32'hC0000, 1'b1}, {32'hC4000, 1'b0}, {32'hDC000, 1'b1}, {32'hE0000, 1'b0},
    {32'hF0000, 1'b0}, {32'h100000, 1'b1}, {32'h3FFFFC, 1'b1}, {32'h400000, 1'b0},
    {32'h200000, 1'b0}, {32'h21FFFC, 1'b0}, {32'h220000, 1'b1}, {32'h1000000, 1'b1},
    {32'hFFFF0000, 1'b1}};

  piad_decoder #(.ISA_HOLE_BLOCKS(128)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_n, .irdy_n, .pci_addr, .pci_cmd, .devsel_n_rx, .devsel_n_drive,
    .devsel_oe, .main_memory_select_n, .isa_forward, .isa_req, .isa_addr,
    .forward_to_pci, .contain_to_isa
  );
  piad_pci_agent i_agent (
    .pclk, .presetn, .frame_n, .irdy_n, .main_memory_select_n, .devsel_n_drive,
    .devsel_oe, .claim_at, .devsel_n_rx
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic give_verdict;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: %s seen %0h expected %0h", $time, m, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    if (pready !== 1'b1) begin
      error_cnt++;
      give_verdict();
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, "read data");
    chk({31'h0, e}, {31'h0, xe}, "slave error");
  endtask : rd

  task automatic pci(input piad_row_t t);
    int nsel = 0;
    int ksel = 0;
    int nfwd = 0;
    int ndrv = 0;
    wr(OFF_MEM_CTL, {24'h0, t.mctl});
    wr(OFF_SAMPLE_CFG, {30'h0, t.cfg});
    @(posedge pclk);
    frame_n  <= 1'b0;
    pci_addr <= t.addr;
    pci_cmd  <= t.cmd;
    claim_at <= t.claim;
    for (int k = 0; k < 12; k++) begin
      @(posedge pclk);
      if (k == 0) begin
        frame_n  <= 1'b1;
        irdy_n   <= 1'b0;
        pci_addr <= ~t.addr;
      end
      if (k == 8) irdy_n <= 1'b1;
      if (main_memory_select_n === 1'b0) begin
        nsel++;
        ksel = k;
      end
      if (isa_forward === 1'b1) nfwd++;
      if (devsel_oe === 1'b1 && devsel_n_drive === 1'b0) ndrv++;
    end
    chk(nsel, {31'h0, t.sel}, "select pulses");
    if (t.sel) chk(ksel, 2, "select edge");
    chk(nfwd, {31'h0, t.fwd}, "isa forward");
    chk({31'h0, ndrv != 0}, {31'h0, t.fwd}, "devsel drive");
    chk({31'h0, devsel_oe}, 32'h0, "devsel release");
  endtask : pci

  initial begin
    repeat (100000) @(posedge pclk);
    error_cnt++;
    give_verdict();
  end

  initial begin
    {presetn, psel, penable, pwrite, isa_req} = 5'h0;
    {paddr, pwdata, pci_addr, isa_addr, pci_cmd, claim_at} = '0;
    {frame_n, irdy_n} = 2'h3;
    error_cnt  = 0;
    n_compared = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 12; a++) rd(12'(a * 4), (a == 11) ? 32'h2 : 32'h0, 1'b0);
    rd(12'h040, 32'h0, 1'b1);
    wr(OFF_ATTR_C, 32'hFFFFFFFF);
    rd(OFF_ATTR_C, 32'hFF, 1'b0);
    $display("test done: registers");
    wr(OFF_ATTR_C, 32'h01);
    wr(OFF_ATTR_D, 32'h80);
    wr(OFF_ATTR_E, 32'h02);
    wr(OFF_MEM_TOP, 32'h01);
    wr(OFF_MEM_HBOT, 32'h18);
    wr(OFF_MEM_HTOP, 32'h18);
    foreach (rows[i]) pci(rows[i]);
    $display("test done: pci decode table");
    wr(OFF_ISA_CTL, 32'h35);
    wr(OFF_ISA_ROM, 32'h81);
    wr(OFF_ISA_HBOT, 32'h20);
    wr(OFF_ISA_HTOP, 32'h21);
    for (int i = 0; i <= 16; i++) begin
      @(posedge pclk);
      isa_req  <= (i < 16);
      isa_addr <= isa_rows[(i < 16) ? i : 0][32:1];
      if (i > 0) begin
        #1;
        chk({31'h0, forward_to_pci}, {31'h0, isa_rows[i-1][0]}, "to pci");
        chk({31'h0, contain_to_isa}, {31'h0, !isa_rows[i-1][0]}, "on isa");
      end
    end
    $display("test done: isa decode back to back");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (8) @(posedge pclk);
    chk({31'h0, main_memory_select_n}, 32'h1, "select in reset");
    chk({31'h0, devsel_oe}, 32'h0, "devsel in reset");
    presetn <= 1'b1;
    rd(OFF_MEM_CTL, 32'h0, 1'b0);
    rd(OFF_SAMPLE_CFG, 32'h2, 1'b0);
    rd(OFF_ATTR_C, 32'h0, 1'b0);
    $display("test done: second reset");
    give_verdict();
  end
endmodule : pci_isa_address_decoder_tb_top
`default_nettype wire
